//--- bench/eeprom_write_protect_addr_cfg_test.sv
// Self-checking bench for the write-protect and address-config logic.
// Assumes the master model in ewp_i2c_master.sv drives the link.
`timescale 1ns/1ns
module eeprom_write_protect_addr_cfg_test;
  import ewp_pkg::*;
  localparam int unsigned TWR = 40;
  logic        clk = 1'b0;
  logic        rst_n;
  logic        scl;
  logic        m_sda;
  logic        sda_line;
  logic        sda_o;
  logic        sda_oe;
  logic        busy;
  logic [7:0]  res;
  logic        res_stb;
  logic [7:0]  e;
  logic [7:0]  r;
  logic [7:0]  old;
  logic [7:0]  d;
  logic [15:0] q;
  logic [2:0]  sel;
  logic [31:0] seed;
  int          fails;
  int          checks;
  logic [7:0]  exp_q[$];

  always #2 clk = ~clk;

  // Pull-up on SDA; either party may pull it low
  assign sda_line = m_sda & (sda_oe ? sda_o : 1'b1);

  ewp_top #(.TWR_CYC(TWR)) ewp_top_inst (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_line),
    .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy));

  ewp_i2c_master ewp_i2c_master_inst (
    .clk(clk), .sda_line(sda_line), .scl(scl), .m_sda(m_sda),
    .res(res), .res_stb(res_stb));

  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] ex,
                     input logic [7:0] got);
    checks++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  // Register word address: select bits on top, the rest random
  function automatic logic [15:0] ra(input logic [1:0] s);
    logic [7:0] a;
    logic [7:0] b;
    a = rnd();
    b = rnd();
    return {s, a[5:0], b};
  endfunction : ra

  function automatic logic [7:0] dw(input logic rw);
    return {DEV_TYPE_CODE, sel, rw};
  endfunction : dw

  task automatic sendb(input logic [7:0] b, input logic ea);
    logic [7:0] rx;
    exp_q.push_back({7'h00, ea});
    ewp_i2c_master_inst.xfer(b, 1'b1, 1'b0, rx);
  endtask : sendb

  task automatic addr_ph(input logic [15:0] wa);
    ewp_i2c_master_inst.start_c();
    sendb(dw(1'b0), 1'b0);
    sendb(wa[15:8], 1'b0);
    sendb(wa[7:0], 1'b0);
  endtask : addr_ph

  task automatic wr(input logic [15:0] wa, input logic [7:0] dat);
    int n;
    addr_ph(wa);
    sendb(dat, 1'b0);
    ewp_i2c_master_inst.stop_c();
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (busy === 1'b1 && n < TWR + 20) begin
      @(negedge clk);
      n++;
    end
    chk("busy cycles", 8'(TWR), 8'(n));
  endtask : wr

  task automatic rd(input logic [15:0] wa, input logic [7:0] ex);
    logic [7:0] rx;
    addr_ph(wa);
    ewp_i2c_master_inst.start_c();
    sendb(dw(1'b1), 1'b0);
    exp_q.push_back(ex);
    ewp_i2c_master_inst.xfer(8'hFF, 1'b1, 1'b1, rx);
    ewp_i2c_master_inst.stop_c();
  endtask : rd

  // Results are judged in arrival order against the notes in exp_q
  always @(posedge res_stb) begin
    if (exp_q.size() == 0) begin
      fails++;
      $display("BAD bus result expected none seen %h", res);
    end else begin
      e = exp_q.pop_front();
      chk("bus result", e, res);
    end
  end

  initial begin
    seed = 32'h0000_0019;
    fails = 0;
    checks = 0;
    sel = 3'h0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    rd(ra(SEL_PROTECT), PROTECT_RESET);
    rd(ra(SEL_ADDR_CFG), {5'h00, ADDR_CFG_RESET});
    r = rnd();
    wr(ra(SEL_ADDR_CFG), {r[7:3], 3'h5});
    // Old select bits must no longer be answered
    ewp_i2c_master_inst.start_c();
    sendb(dw(1'b0), 1'b1);
    ewp_i2c_master_inst.stop_c();
    sel = 3'h5;
    r = rnd();
    wr(ra(SEL_PROTECT), {r[7:4], 1'b0, PROT_ALL, r[0]});
    old = rnd();
    wr(16'h3000, old);
    // Each size: the edge refuses; for the three partial sizes the next quarter down stays writable
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      wr(ra(SEL_PROTECT), {r[7:4], 1'b1, s[1:0], r[0]});
      q = 16'h3000 - 16'(s) * 16'h1000;
      d = rnd();
      if (s < 3) begin
        wr(q - 16'h1000, d);
      end
      wr(q, ~old);
      rd(q, old);
      old = d;
    end
    rd(ra(SEL_PROTECT), PROTECT_LOCK_ALL);
    r = rnd();
    wr(ra(SEL_ADDR_CFG), {r[7:3], 3'h2});
    rd(ra(SEL_ADDR_CFG), 8'h05);
    // Current read with master ack: register stays selected for both
    ewp_i2c_master_inst.start_c();
    sendb(dw(1'b1), 1'b0);
    exp_q.push_back(8'h05);
    ewp_i2c_master_inst.xfer(8'hFF, 1'b0, 1'b1, r);
    exp_q.push_back(8'h05);
    ewp_i2c_master_inst.xfer(8'hFF, 1'b1, 1'b1, r);
    ewp_i2c_master_inst.stop_c();
    repeat (10) @(negedge clk);
    chk("pending results", 8'h00, 8'(exp_q.size()));
    close_out();
  end
endmodule : eeprom_write_protect_addr_cfg_test

//--- bench/ewp_i2c_master.sv
// Two-wire bus master model that stands in for the host controller.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/1ns
module ewp_i2c_master (
  input  wire logic       clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            m_sda,
  output logic [7:0]      res,
  output logic            res_stb
);
  logic tck;

  // Link tick of 48 ns, odd offset so it never lines up with clk
  initial begin
    tck = 1'b0;
    #5;
    forever #24 tck = ~tck;
  end

  initial begin
    scl = 1'b1;
    m_sda = 1'b1;
    res = 8'h00;
    res_stb = 1'b0;
  end

  // Inputs move just after a falling clk edge, never on the sampling one
  task automatic tk(input int n);
    repeat (n) @(posedge tck);
    @(negedge clk);
  endtask : tk

  // Phases of five ticks keep SCL high and low above 200 ns
  task automatic bitx(input logic b, output logic r);
    tk(2);
    m_sda = b;
    tk(3);
    scl = 1'b1;
    tk(3);
    r = sda_line;
    tk(2);
    scl = 1'b0;
  endtask : bitx

  task automatic start_c();
    tk(2);
    m_sda = 1'b1;
    tk(3);
    scl = 1'b1;
    tk(3);
    m_sda = 1'b0;
    tk(2);
    scl = 1'b0;
  endtask : start_c

  // SCL then rests high: the link clock stands still between frames
  task automatic stop_c();
    tk(2);
    m_sda = 1'b0;
    tk(3);
    scl = 1'b1;
    tk(3);
    m_sda = 1'b1;
  endtask : stop_c

  task automatic xfer(input logic [7:0] tx, input logic mack,
                      input logic is_rd, output logic [7:0] rx);
    logic ack;
    for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
    bitx(mack, ack);
    res = is_rd ? rx : {7'h00, ack};
    // Strobe drops a clock later so back-to-back bytes never collide
    res_stb = 1'b1;
    @(negedge clk);
    res_stb = 1'b0;
  endtask : xfer
endmodule : ewp_i2c_master

//--- verilog/ewp_link_rx.sv
// Link-side bit capture, clocked by SCL itself.
// Each rising SCL edge holds the SDA bit and flips a toggle; the system
// side picks the bit up when it sees the toggle change.
`timescale 1ns/1ns
module ewp_link_rx (
  input  wire logic scl,
  input  wire logic rst_n,
  input  wire logic sda_i,
  output logic      bit_val,
  output logic      bit_tgl
);
  // Bit stays put for a whole SCL period, far longer than the crossing
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      bit_val <= 1'b0;
      bit_tgl <= 1'b0;
    end else begin
      bit_val <= sda_i;
      bit_tgl <= ~bit_tgl;
    end
  end
endmodule : ewp_link_rx

//--- verilog/ewp_mem.sv
// Byte array of the EEPROM: one write port, one read port whose data
// come out of a register one clock after the request.
// Contents are not reset; unwritten bytes read undefined in simulation.
`timescale 1ns/1ns
module ewp_mem
  import ewp_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic              re,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata
);
  logic [7:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : ewp_mem

//--- verilog/ewp_pkg.sv
// Constants, encodings and types shared by the write-protect and
// address-configuration logic of the serial EEPROM.
// Assumes a 250 MHz system clock; SCL is slow beside it.
package ewp_pkg;
  localparam int         ADDR_W           = 14;
  localparam int         PAGE_W           = 6;
  localparam logic [1:0] SEL_PROTECT      = 2'h3;
  localparam logic [1:0] SEL_ADDR_CFG     = 2'h2;
  localparam int         PROT_EN_BIT      = 3;
  localparam int         PROT_SIZE_HI     = 2;
  localparam int         PROT_SIZE_LO     = 1;
  localparam logic [1:0] PROT_QUARTER     = 2'h0;
  localparam logic [1:0] PROT_HALF        = 2'h1;
  localparam logic [1:0] PROT_THREE_QTR   = 2'h2;
  localparam logic [1:0] PROT_ALL         = 2'h3;
  localparam logic [7:0] PROTECT_RESET    = 8'h00;
  localparam logic [7:0] PROTECT_LOCK_ALL = 8'h0E;
  localparam logic [2:0] ADDR_CFG_RESET   = 3'h0;
  // Arbitrary device type code, stands in for the fixed upper nibble
  localparam logic [3:0] DEV_TYPE_CODE    = 4'h5;
  localparam logic [3:0] BIT_LAST         = 4'h7;
  localparam logic [3:0] BIT_ACK          = 4'h8;
  localparam int         TWR_MS           = 3;
  localparam int         CLK_MHZ          = 250;
  localparam int         TWR_CYCLES       = TWR_MS * CLK_MHZ * 1000;
  localparam int         TWR_CNT_W        = 20;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DEV   = 3'b001,
    ST_AHI   = 3'b010,
    ST_ALO   = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101
  } ewp_state_t;
endpackage : ewp_pkg

//--- verilog/ewp_top.sv
// Serial EEPROM slave with block write protection and a configurable
// device address, both held in registers reached over the two-wire bus.
// Assumes SDA/SCL are open drain with pull-ups outside; sda_o is always
// low and sda_oe pulls the line.
`timescale 1ns/1ns
module ewp_top
  import ewp_pkg::*;
#(
  parameter int unsigned TWR_CYC = TWR_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      busy
);
  logic [2:0]           scl_sync_reg;
  logic [2:0]           sda_sync_reg;
  logic                 scl_f_reg;
  logic                 sda_f_reg;
  logic [2:0]           tgl_sync_reg;
  logic                 link_bit;
  logic                 link_tgl;
  ewp_state_t           state_reg;
  ewp_state_t           nxt_reg;
  logic [3:0]           cnt_reg;
  logic                 ack_pend_reg;
  logic [7:0]           rx_reg;
  logic [7:0]           hi_reg;
  logic [ADDR_W-1:0]    addr_ptr_reg;
  logic [1:0]           reg_sel_reg;
  logic [7:0]           protect_cfg_reg;
  logic [2:0]           addr_cfg_reg;
  logic                 wrote_reg;
  logic                 busy_reg;
  logic [TWR_CNT_W-1:0] twr_cnt_reg;
  logic                 rd_req_reg;
  logic                 rd_vld_reg;
  logic [7:0]           rbyte_reg;
  logic [7:0]           mem_rdata;
  logic                 sda_oe_reg;
  logic                 sda_o_reg;
  logic                 scl_next;
  logic                 sda_next;
  logic                 scl_fall;
  logic                 start_ev;
  logic                 stop_ev;
  logic                 bit_ev;
  logic [7:0]           rx_full;
  logic                 byte_done;
  logic                 ack_done;
  logic                 wr_ev;
  logic                 dev_match;
  logic                 prot_hit;
  logic                 mem_we;
  logic                 rd_req_next;

  ewp_link_rx u_link (
    .scl     (scl),
    .rst_n   (rst_n),
    .sda_i   (sda_i),
    .bit_val (link_bit),
    .bit_tgl (link_tgl)
  );

  ewp_mem u_mem (
    .clk   (clk),
    .rst_n (rst_n),
    .we    (mem_we),
    .waddr (addr_ptr_reg),
    .wdata (rx_full),
    .re    (rd_req_reg),
    .raddr (addr_ptr_reg),
    .rdata (mem_rdata)
  );

  // Pins pass three flops; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_f_reg    <= scl_next;
      sda_f_reg    <= sda_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_sync_reg <= 3'h0;
    end else begin
      tgl_sync_reg <= {tgl_sync_reg[1:0], link_tgl};
    end
  end

  always_comb begin
    scl_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2]
                                                     : scl_f_reg;
    sda_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2]
                                                     : sda_f_reg;
    scl_fall = scl_f_reg & ~scl_next;
    start_ev = scl_f_reg & scl_next & sda_f_reg & ~sda_next;
    stop_ev  = scl_f_reg & scl_next & ~sda_f_reg & sda_next;
    bit_ev   = tgl_sync_reg[1] ^ tgl_sync_reg[2];
    rx_full  = {rx_reg[6:0], link_bit};
    byte_done = bit_ev && (cnt_reg == BIT_LAST) &&
                (state_reg != ST_IDLE) && (state_reg != ST_RDATA);
    ack_done  = bit_ev && (cnt_reg == BIT_ACK) && (state_reg == ST_RDATA);
    wr_ev     = byte_done && (state_reg == ST_WDATA);
    dev_match = (rx_full[7:4] == DEV_TYPE_CODE) &&
                (rx_full[3:1] == addr_cfg_reg);
  end

  // Protected region from the size field, upper part of the array
  always_comb begin
    unique case (protect_cfg_reg[PROT_SIZE_HI:PROT_SIZE_LO])
      PROT_QUARTER:   prot_hit = &addr_ptr_reg[ADDR_W-1:ADDR_W-2];
      PROT_HALF:      prot_hit = addr_ptr_reg[ADDR_W-1];
      PROT_THREE_QTR: prot_hit = |addr_ptr_reg[ADDR_W-1:ADDR_W-2];
      PROT_ALL:       prot_hit = 1'b1;
    endcase
    prot_hit = prot_hit & protect_cfg_reg[PROT_EN_BIT];
    mem_we   = wr_ev && !reg_sel_reg[1] && !prot_hit;
    rd_req_next = (byte_done && (state_reg == ST_DEV) && dev_match &&
                   rx_full[0]) || (ack_done && !link_bit);
  end

  // Byte framing; a start during the write cycle is not answered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      nxt_reg      <= ST_IDLE;
      cnt_reg      <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (start_ev && !busy_reg) begin
      state_reg    <= ST_DEV;
      cnt_reg      <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      ack_pend_reg <= 1'b0;
    end else if (bit_ev && state_reg != ST_IDLE) begin
      if (cnt_reg == BIT_ACK) begin
        cnt_reg      <= 4'h0;
        ack_pend_reg <= 1'b0;
        if (state_reg == ST_RDATA) begin
          state_reg <= link_bit ? ST_IDLE : ST_RDATA;
        end else begin
          state_reg <= nxt_reg;
        end
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
      if (byte_done) begin
        unique case (state_reg)
          ST_DEV: begin
            ack_pend_reg <= dev_match;
            nxt_reg <= !dev_match ? ST_IDLE :
                       (rx_full[0] ? ST_RDATA : ST_AHI);
          end
          ST_AHI: begin
            ack_pend_reg <= 1'b1;
            nxt_reg      <= ST_ALO;
          end
          ST_ALO: begin
            ack_pend_reg <= 1'b1;
            nxt_reg      <= ST_WDATA;
          end
          ST_WDATA: begin
            ack_pend_reg <= 1'b1;
            nxt_reg      <= ST_WDATA;
          end
          default: begin
            ack_pend_reg <= 1'b0;
            nxt_reg      <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= 8'h00;
    end else if (bit_ev && cnt_reg < BIT_ACK) begin
      rx_reg <= rx_full;
    end
  end

  // Word address and pointer; writes wrap inside the page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_reg       <= 8'h00;
      addr_ptr_reg <= '0;
      reg_sel_reg  <= 2'h0;
    end else if (byte_done && state_reg == ST_AHI) begin
      hi_reg <= rx_full;
    end else if (byte_done && state_reg == ST_ALO) begin
      addr_ptr_reg <= {hi_reg[ADDR_W-9:0], rx_full};
      reg_sel_reg  <= hi_reg[7:6];
    end else if (wr_ev && !reg_sel_reg[1]) begin
      addr_ptr_reg[PAGE_W-1:0] <= addr_ptr_reg[PAGE_W-1:0] + 6'h01;
    end else if (ack_done) begin
      addr_ptr_reg <= addr_ptr_reg + 14'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      protect_cfg_reg <= PROTECT_RESET;
    end else if (wr_ev && reg_sel_reg == SEL_PROTECT) begin
      protect_cfg_reg <= {4'h0, rx_full[3:1], 1'b0};
    end
  end

  // Reset stands for the delivered state; a real part keeps this value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_cfg_reg <= ADDR_CFG_RESET;
    end else if (wr_ev && reg_sel_reg == SEL_ADDR_CFG &&
                 protect_cfg_reg != PROTECT_LOCK_ALL) begin
      addr_cfg_reg <= rx_full[2:0];
    end
  end

  // Read path: one clock for the pointer to settle, one for the array
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_req_reg <= 1'b0;
      rd_vld_reg <= 1'b0;
      rbyte_reg  <= 8'h00;
    end else begin
      rd_req_reg <= rd_req_next;
      rd_vld_reg <= rd_req_reg;
      if (rd_vld_reg) begin
        unique case (reg_sel_reg)
          SEL_PROTECT:  rbyte_reg <= protect_cfg_reg;
          SEL_ADDR_CFG: rbyte_reg <= {5'h00, addr_cfg_reg};
          default:      rbyte_reg <= mem_rdata;
        endcase
      end
    end
  end

  // Write cycle starts at the stop that ends a write with data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote_reg   <= 1'b0;
      busy_reg    <= 1'b0;
      twr_cnt_reg <= '0;
    end else begin
      if (wr_ev) begin
        wrote_reg <= 1'b1;
      end else if (stop_ev) begin
        wrote_reg <= 1'b0;
      end
      if (stop_ev && wrote_reg) begin
        busy_reg    <= 1'b1;
        twr_cnt_reg <= TWR_CNT_W'(TWR_CYC - 1);
      end else if (busy_reg) begin
        if (twr_cnt_reg == '0) begin
          busy_reg <= 1'b0;
        end else begin
          twr_cnt_reg <= twr_cnt_reg - 1'b1;
        end
      end
    end
  end

  // Drive only while SCL is low so no false start or stop appears
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_reg <= 1'b0;
      sda_o_reg  <= 1'b0;
    end else if (start_ev || stop_ev || busy_reg) begin
      sda_oe_reg <= 1'b0;
    end else if (scl_fall) begin
      if (cnt_reg == BIT_ACK && ack_pend_reg) begin
        sda_oe_reg <= 1'b1;
      end else if (state_reg == ST_RDATA && cnt_reg < BIT_ACK) begin
        sda_oe_reg <= ~rbyte_reg[~cnt_reg[2:0]];
      end else begin
        sda_oe_reg <= 1'b0;
      end
    end
  end

  assign sda_o  = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign busy   = busy_reg;

  a_busy_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
    busy_reg |=> !sda_oe_reg)
    else $error("sda driven during write cycle");
  a_busy_length: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(busy_reg) |-> busy_reg [*8])
    else $error("write cycle ended too early");
  a_protect_rsvd: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ev && reg_sel_reg == SEL_PROTECT |=>
      protect_cfg_reg == {4'h0, $past(rx_full[3:1]), 1'b0})
    else $error("protect register write not decoded");
  a_protect_zero: assert property (@(posedge clk) disable iff (!rst_n)
    protect_cfg_reg[7:4] == 4'h0 && !protect_cfg_reg[0])
    else $error("protect reserved bits not zero");
  a_addr_cfg_wr: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ev && reg_sel_reg == SEL_ADDR_CFG &&
    protect_cfg_reg != PROTECT_LOCK_ALL |=>
      addr_cfg_reg == $past(rx_full[2:0]))
    else $error("address config write lost");
  a_addr_cfg_lock: assert property (@(posedge clk) disable iff (!rst_n)
    protect_cfg_reg == PROTECT_LOCK_ALL |=> $stable(addr_cfg_reg))
    else $error("locked address config changed");
  a_prot_block: assert property (@(posedge clk) disable iff (!rst_n)
    mem_we |-> !protect_cfg_reg[3] ||
      (protect_cfg_reg[2:1] == 2'h0 && addr_ptr_reg[13:12] != 2'h3) ||
      (protect_cfg_reg[2:1] == 2'h1 && !addr_ptr_reg[13]) ||
      (protect_cfg_reg[2:1] == 2'h2 && addr_ptr_reg[13:12] == 2'h0))
    else $error("write into protected block");
  a_no_ack_miss: assert property (@(posedge clk) disable iff (!rst_n)
    byte_done && state_reg == ST_DEV && !dev_match |=>
      !ack_pend_reg && nxt_reg == ST_IDLE)
    else $error("acked foreign device address");
  a_page_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ev && !reg_sel_reg[1] |=>
      addr_ptr_reg[13:6] == $past(addr_ptr_reg[13:6]))
    else $error("write crossed page row");
endmodule : ewp_top
